// ===== hdl/wdrc_cfg.svh
/*
 * constants of the watchdog restart control: rates, divider settings,
 * register indexes, field positions and reset values.
 * assumes it is included by bare name, after wdrc_pkg where types are needed.
 */
`ifndef WDRC_CFG_SVH
`define WDRC_CFG_SVH

// clock rates in hz
`define WDRC_SYS_CLK_HZ 64'h0000_0000_05F5_E100
`define WDRC_LSC_HZ 64'h0000_0000_0000_8000

// phase step of the low-speed clock accumulator: lsc_hz * 2^32 / sys_clk_hz
`define WDRC_LSC_STEP (((`WDRC_LSC_HZ) << 32) / (`WDRC_SYS_CLK_HZ))

// low-speed clock divided by 128 gives the 256 hz count tick
`define WDRC_PRE_LAST 7'h7F
`define WDRC_CNT_LAST 10'h3FF

// register indexes; byte address is four times the index
`define WDRC_CTRL_IDX 16'hFF07
`define WDRC_STAT_IDX 16'hFF08
`define WDRC_MASK_IDX 16'hFF09
`define WDRC_CNT_IDX 16'hFF0A

// field positions
`define WDRC_RST_BIT 0
`define WDRC_EN_BIT 1
`define WDRC_OVF_BIT 0

// reset values
`define WDRC_EN_RST 1'b1
`define WDRC_MASK_RST 1'b0
`define WDRC_STAT_RST 1'b0

`endif

// ===== hdl/wdrc_pkg.sv
/*
 * types shared by the watchdog restart control modules.
 * assumes nothing of its surroundings.
 */
package wdrc_pkg;
   typedef logic [9:0] wdrc_cnt_t;
   typedef logic [6:0] wdrc_pre_t;
   typedef logic [31:0] wdrc_word_t;
endpackage : wdrc_pkg

// ===== hdl/wdrc_tick_div.sv
/*
 * tick divider: makes a 32.768 khz low-speed clock enable from sys_clk by a
 * phase accumulator, then divides it by 128 into the 256 hz count tick.
 * assumes a synchronous active-low reset copy and one clock domain.
 */
`timescale 1ns/100ps
`include "wdrc_cfg.svh"

module wdrc_tick_div #(
   parameter logic [31:0] lsc_step = 32'(`WDRC_LSC_STEP)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_sync_b,
   // enables out
   output logic lsc_tick,
   output logic cnt_tick
);
   import wdrc_pkg::*;

   logic [32:0] acc_sum;
   logic [31:0] acc_r;
   logic [31:0] acc_nxt;
   wdrc_pre_t pre_r;
   wdrc_pre_t pre_nxt;

   // carry out of the accumulator is one low-speed clock period; jitter is one sys_clk
   always_comb
   begin
      acc_sum = {1'b0, acc_r} + {1'b0, lsc_step};
      acc_nxt = acc_sum[31:0];
      lsc_tick = acc_sum[32];
      pre_nxt = pre_r;
      if (lsc_tick)
      begin
         pre_nxt = wdrc_pre_t'(pre_r + 7'h01);
      end
      cnt_tick = lsc_tick && (pre_r == `WDRC_PRE_LAST);
   end

   always_ff @(posedge sys_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         acc_r <= 32'h0000_0000;
         pre_r <= 7'h00;
      end
      else
      begin
         acc_r <= acc_nxt;
         pre_r <= pre_nxt;
      end
   end
endmodule : wdrc_tick_div

// ===== hdl/wdrc_wd_counter.sv
/*
 * 10-bit watchdog count chain with restart clear and overflow flag.
 * assumes tick is a one-cycle enable and clr a one-cycle restart strobe.
 */
`timescale 1ns/100ps
`include "wdrc_cfg.svh"

module wdrc_wd_counter (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_sync_b,
   // control
   input wire logic tick,
   input wire logic en,
   input wire logic clr,
   // state
   output wdrc_pkg::wdrc_cnt_t cnt,
   output logic ovf
);
   import wdrc_pkg::*;

   wdrc_cnt_t cnt_r;
   wdrc_cnt_t cnt_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      ovf = 1'b0;
      if (clr)
      begin
         // restart wins over a coincident tick
         cnt_nxt = 10'h000;
      end
      else if (en && tick)
      begin
         cnt_nxt = wdrc_cnt_t'(cnt_r + 10'h001);
         ovf = (cnt_r == `WDRC_CNT_LAST);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         cnt_r <= 10'h000;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   assign cnt = cnt_r;
endmodule : wdrc_wd_counter

// ===== hdl/wdrc_top.sv
/*
 * watchdog restart control: wishbone register slave, 256 hz tick divider,
 * 10-bit watchdog counter, non-maskable interrupt request and a maskable
 * event interrupt.
 * assumes classic wishbone with 32-bit data, one clock, and a cpu core that
 * takes nmi_o as a one-cycle request.
 */
// Added by the designer: the Wishbone interface to the registers.
// Overview of operation
// R01: writing restart one clears count, counting resumes
// R02: writing restart zero changes nothing
// R03: restart bit always reads back zero
// R04: software restarts within three seconds when enabled
// R05: watchdog enabled and counting after reset
// R06: unused watchdog disabled early by software
// R07: count chain clocked from divided 32.768 khz
// R08: count input is 256 hz tick
// R09: 10-bit counter, overflow requests nmi
// R10: enable zero stops counting and nmi
// R11: counting continues while cpu halted
// R12: one nmi per overflow, counter wraps
`timescale 1ns/100ps
`include "wdrc_cfg.svh"

module wdrc_top #(
   parameter logic [31:0] lsc_step = 32'(`WDRC_LSC_STEP)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire wdrc_pkg::wdrc_word_t wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire wdrc_pkg::wdrc_word_t wb_dat_i,
   output wdrc_pkg::wdrc_word_t wb_dat_o,
   output logic wb_ack_o,
   // interrupts
   output logic nmi_o,
   output logic irq_o
);
   import wdrc_pkg::*;

   // reset release
   logic rst_meta_r;
   logic rst_sync_b;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_b <= rst_meta_r;
      end
   end

   // tick generation and counter
   logic lsc_tick;
   logic cnt_tick;
   logic en_r;
   logic en_nxt;
   logic restart;
   wdrc_cnt_t cnt;
   logic ovf;

   wdrc_tick_div #(
      .lsc_step(lsc_step)
   ) u_div (
      .sys_clk(sys_clk),
      .rst_sync_b(rst_sync_b),
      .lsc_tick(lsc_tick), // R07
      .cnt_tick(cnt_tick) // R08
   );

   // the halt state of the cpu is not an input: nothing here stops the count
   wdrc_wd_counter u_cnt (
      .sys_clk(sys_clk),
      .rst_sync_b(rst_sync_b),
      .tick(cnt_tick), // R11
      .en(en_r), // R10
      .clr(restart), // R01
      .cnt(cnt),
      .ovf(ovf) // R09
   );

   // bus decode
   logic req;
   logic in_page;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_mask;
   logic hit_cnt;
   logic wr_lo;
   logic rd_stat;

   always_comb
   begin
      // answer once per request; ack drops in the cycle after it was given
      req = wb_cyc_i && wb_stb_i && !wb_ack_o;
      in_page = (wb_adr_i[31:18] == 14'h0000) && (wb_adr_i[1:0] == 2'h0);
      hit_ctrl = 1'b0;
      hit_stat = 1'b0;
      hit_mask = 1'b0;
      hit_cnt = 1'b0;
      if (in_page && (wb_adr_i[17:2] == `WDRC_CTRL_IDX))
      begin
         hit_ctrl = 1'b1;
      end
      else if (in_page && (wb_adr_i[17:2] == `WDRC_STAT_IDX))
      begin
         hit_stat = 1'b1;
      end
      else if (in_page && (wb_adr_i[17:2] == `WDRC_MASK_IDX))
      begin
         hit_mask = 1'b1;
      end
      else if (in_page && (wb_adr_i[17:2] == `WDRC_CNT_IDX))
      begin
         hit_cnt = 1'b1;
      end
      wr_lo = req && wb_we_i && wb_sel_i[0];
      rd_stat = req && !wb_we_i && hit_stat;
   end

   // control register
   always_comb
   begin
      en_nxt = en_r;
      restart = 1'b0;
      if (wr_lo && hit_ctrl)
      begin
         en_nxt = wb_dat_i[`WDRC_EN_BIT]; // R10
         restart = wb_dat_i[`WDRC_RST_BIT]; // R01 R02
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         en_r <= `WDRC_EN_RST; // R05
      end
      else
      begin
         en_r <= en_nxt;
      end
   end

   // event status, mask and interrupt outputs
   logic stat_r;
   logic stat_nxt;
   logic mask_r;
   logic mask_nxt;
   logic irq_nxt;
   logic nmi_nxt;

   always_comb
   begin
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      if (rd_stat)
      begin
         stat_nxt = 1'b0;
      end
      // an overflow in the clearing cycle is kept
      if (ovf)
      begin
         stat_nxt = 1'b1;
      end
      if (wr_lo && hit_mask)
      begin
         mask_nxt = wb_dat_i[`WDRC_OVF_BIT];
      end
      irq_nxt = stat_nxt && mask_nxt;
      nmi_nxt = ovf; // R09 R12
   end

   always_ff @(posedge sys_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         stat_r <= `WDRC_STAT_RST;
         mask_r <= `WDRC_MASK_RST;
         irq_o <= 1'b0;
         nmi_o <= 1'b0;
      end
      else
      begin
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_o <= irq_nxt;
         nmi_o <= nmi_nxt;
      end
   end

   // bus answer; unmapped addresses are acknowledged and read as zero
   wdrc_word_t dat_nxt;
   logic ack_nxt;

   always_comb
   begin
      ack_nxt = req;
      dat_nxt = 32'h0000_0000;
      if (req && !wb_we_i)
      begin
         if (hit_ctrl)
         begin
            // the restart position is never stored, so it reads zero
            dat_nxt[`WDRC_EN_BIT] = en_r; // R03
         end
         else if (hit_stat)
         begin
            dat_nxt[`WDRC_OVF_BIT] = stat_r;
         end
         else if (hit_mask)
         begin
            dat_nxt[`WDRC_OVF_BIT] = mask_r;
         end
         else if (hit_cnt)
         begin
            dat_nxt[9:0] = cnt;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= ack_nxt;
         wb_dat_o <= dat_nxt;
      end
   end

   // low-speed enables since the last count tick; an 8-bit count so a wrong
   // divide of 256 is not hidden by a wrap at 128
   logic [7:0] lsc_seen_r;
   logic [7:0] lsc_seen_nxt;

   always_comb
   begin
      lsc_seen_nxt = lsc_seen_r;
      if (cnt_tick)
      begin
         lsc_seen_nxt = 8'h00;
      end
      else if (lsc_tick)
      begin
         lsc_seen_nxt = 8'(lsc_seen_r + 8'h01);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         lsc_seen_r <= 8'h00;
      end
      else
      begin
         lsc_seen_r <= lsc_seen_nxt;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_sync_b);

   sequence s_restart_write;
      wr_lo && hit_ctrl && wb_dat_i[`WDRC_RST_BIT];
   endsequence

   sequence s_keep_write;
      wr_lo && hit_ctrl && !wb_dat_i[`WDRC_RST_BIT] && !cnt_tick;
   endsequence

   sequence s_ctrl_read;
      req && !wb_we_i && hit_ctrl;
   endsequence

   a_restart_clears: assert property (s_restart_write |=> (cnt == 10'h000)) // R01
      else $error("restart write did not clear the count");

   a_restart_resume: assert property (s_restart_write ##1 (en_r && cnt_tick && !restart)
      |=> (cnt == 10'h001)) // R01
      else $error("count did not resume after restart");

   a_zero_write_keeps: assert property (s_keep_write |=> $stable(cnt)) // R02
      else $error("writing restart zero changed the count");

   a_restart_reads_zero: assert property (s_ctrl_read |=> wb_ack_o && !wb_dat_o[`WDRC_RST_BIT]) // R03
      else $error("restart bit read back non-zero");

   a_reset_enabled: assert property (!$past(rst_sync_b) |-> en_r && (cnt == 10'h000)) // R05
      else $error("watchdog not enabled after reset");

   a_tick_division: assert property (cnt_tick |-> lsc_seen_r == {1'b0, `WDRC_PRE_LAST}) // R08
      else $error("count tick not on every 128th low-speed enable");

   a_tick_on_lsc: assert property (cnt_tick |-> lsc_tick) // R08
      else $error("count tick not aligned to low-speed enable");

   a_disabled_holds: assert property (!en_r && !restart |=> $stable(cnt) && !nmi_o) // R10
      else $error("disabled watchdog counted or raised nmi");

   a_nmi_on_wrap: assert property (en_r && cnt_tick && !restart && (cnt == `WDRC_CNT_LAST)
      |=> nmi_o && (cnt == 10'h000)) // R09
      else $error("overflow did not wrap and raise nmi");

   a_nmi_single: assert property (nmi_o |=> !nmi_o) // R12
      else $error("nmi request longer than one cycle");

   a_nmi_cause: assert property ($rose(nmi_o) |-> $past(cnt) == `WDRC_CNT_LAST) // R12
      else $error("nmi without counter overflow");

   a_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");
endmodule : wdrc_top

// ===== tb/wdrc_cpu_model.sv
/*
 * cpu core model: takes the non-maskable interrupt request, which ends halt.
 * assumes nmi_i is a registered pulse in the sys_clk domain.
 */
`timescale 1ns/100ps

module wdrc_cpu_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // request from the watchdog
   input wire logic nmi_i,
   // observed state
   output int nmi_taken,
   output int nmi_wide,
   output logic halted
);
   logic nmi_q;

   // the core sits halted from reset, so only the watchdog can wake it
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         nmi_taken <= 0;
         nmi_wide <= 0;
         nmi_q <= 1'b0;
         halted <= 1'b1;
      end
      else
      begin
         nmi_q <= nmi_i;
         if (nmi_i && !nmi_q)
         begin
            nmi_taken <= nmi_taken + 1;
            halted <= 1'b0;
         end
         if (nmi_i && nmi_q)
         begin
            nmi_wide <= nmi_wide + 1;
         end
      end
   end
endmodule : wdrc_cpu_model

// ===== tb/tb.sv
/*
 * testbench of the watchdog restart control, driven over wishbone.
 * assumes lsc_step near 2^32, so a count tick comes every 128 clocks.
 */
`timescale 1ns/100ps
`include "wdrc_cfg.svh"

module tb;
   import wdrc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   wdrc_word_t wb_adr_i = '0;
   logic [3:0] wb_sel_i = 4'h0;
   wdrc_word_t wb_dat_i = '0;
   wdrc_word_t wb_dat_o;
   logic wb_ack_o, nmi_o, irq_o, halted;
   int nmi_taken, nmi_wide, t0;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   wdrc_word_t d, c0;

   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cycles <= cycles + 1;

   wdrc_top #(.lsc_step(32'hFFFF_FFFF)) u_wdrc_top (
      .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .nmi_o(nmi_o), .irq_o(irq_o));

   wdrc_cpu_model u_wdrc_cpu_model (
      .sys_clk(sys_clk), .rst_b(rst_b), .nmi_i(nmi_o),
      .nmi_taken(nmi_taken), .nmi_wide(nmi_wide), .halted(halted));

   task automatic check(input wdrc_word_t seen, input wdrc_word_t exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   task automatic xfer(input logic we, input logic [15:0] idx, input wdrc_word_t wd,
                       output wdrc_word_t rd);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {14'h0000, idx, 2'b00};
      wb_sel_i <= 4'h1;
      wb_dat_i <= wd;
      do
      begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         bad_count++;
         $display("[ERR] %0t: no ack from the register bus", $time);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : xfer

   // a hang anywhere ends the run as a mismatch
   initial
   begin
      repeat (150000) @(posedge sys_clk);
      bad_count++;
      $display("[ERR] %0t: run did not finish in time", $time);
      end_of_test();
   end

   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      xfer(1'b0, `WDRC_CTRL_IDX, 0, d);
      check(d, 32'h0000_0002);
      xfer(1'b0, `WDRC_MASK_IDX, 0, d);
      check(d, 32'h0000_0000);
      xfer(1'b0, 16'hFF0B, 0, d);
      check(d, 32'h0000_0000);
      repeat (1300) @(posedge sys_clk);
      xfer(1'b0, `WDRC_CNT_IDX, 0, c0);
      check(32'(c0 >= 9 && c0 <= 11), 32'h0000_0001);
      xfer(1'b1, `WDRC_CTRL_IDX, 32'h0000_0002, d);
      xfer(1'b0, `WDRC_CNT_IDX, 0, d);
      check(32'(d >= c0), 32'h0000_0001);
      // count ticks land on edges 23 + 128k; take the restart one edge before a tick
      while (cycles % 128 != 19)
         @(posedge sys_clk);
      xfer(1'b1, `WDRC_CTRL_IDX, 32'h0000_0003, d);
      xfer(1'b0, `WDRC_CNT_IDX, 0, d);
      check(d, 32'h0000_0001);
      repeat (640) @(posedge sys_clk);
      xfer(1'b0, `WDRC_CNT_IDX, 0, d);
      check(32'(d >= 5 && d <= 6), 32'h0000_0001);
      // disabled: count frozen, no request
      xfer(1'b1, `WDRC_CTRL_IDX, 32'h0000_0000, d);
      xfer(1'b0, `WDRC_CNT_IDX, 0, c0);
      repeat (1000) @(posedge sys_clk);
      xfer(1'b0, `WDRC_CNT_IDX, 0, d);
      check(d, c0);
      xfer(1'b0, `WDRC_CTRL_IDX, 0, d);
      check(d, 32'h0000_0000);
      xfer(1'b1, `WDRC_CTRL_IDX, 32'h0000_0002, d);
      repeat (300) @(posedge sys_clk);
      xfer(1'b0, `WDRC_CNT_IDX, 0, d);
      check(32'(d >= c0 + 2), 32'h0000_0001);
      check(nmi_taken, 0);
      // left alone after a restart, the counter overflows after 1024 ticks
      xfer(1'b1, `WDRC_MASK_IDX, 32'h0000_0001, d);
      xfer(1'b1, `WDRC_CTRL_IDX, 32'h0000_0003, d);
      t0 = cycles;
      while (nmi_taken == 0 && cycles - t0 < 140000)
         @(posedge sys_clk);
      check(32'(cycles - t0 >= 130900 && cycles - t0 <= 131100), 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      check(32'(irq_o), 32'h0000_0001);
      check(32'(halted), 32'h0000_0000);
      xfer(1'b0, `WDRC_STAT_IDX, 0, d);
      check(d, 32'h0000_0001);
      xfer(1'b0, `WDRC_STAT_IDX, 0, d);
      check(d, 32'h0000_0000);
      check(32'(irq_o), 32'h0000_0000);
      repeat (300) @(posedge sys_clk);
      xfer(1'b0, `WDRC_CNT_IDX, 0, d);
      check(32'(d >= 2 && d <= 4), 32'h0000_0001);
      check(nmi_taken, 1);
      check(nmi_wide, 0);
      end_of_test();
   end
endmodule : tb
